// File: ccc_pkg.sv
package ccc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_CFG = 8'h32;
  localparam logic [7:0] IDX_DATAPATH = 8'h33;
  localparam logic [7:0] IDX_RSVD_34 = 8'h34;
  localparam logic [7:0] IDX_CAP_ONE = 8'h35;
  localparam logic [7:0] IDX_RSVD_36 = 8'h36;
  localparam logic [7:0] IDX_PARTNER_ID = 8'h37;
  localparam logic [7:0] IDX_RSVD_38 = 8'h38;
  // Field positions
  localparam int CFG_PASS_ALL = 7;
  localparam int CFG_PASS_DECODE = 6;
  localparam int CFG_ACK_ALL = 5;
  localparam int CFG_PARITY_ON = 3;
  localparam int DP_CRC_ON = 2;
  localparam int DP_GPIO_LSB = 0;
  localparam int CAP_FREEZE = 7;
  localparam int CAP_SELFTEST = 5;
  localparam int CAP_MULTI_PORT = 4;
  localparam int CAP_PORT_LSB = 0;
  localparam int ID_FREEZE = 0;
  localparam int ID_LSB = 1;
  // Reset values
  localparam logic [7:0] RST_CHAN_CFG = 8'h09;
  localparam logic [7:0] RST_DATAPATH = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Partner identifier reset; value is arbitrary
  localparam logic [6:0] RST_PARTNER_ID = 7'h2a;
  // Control sequence CRC
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [3:0] CRC_DATA_BYTES = 4'h8;
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Thermometer mask of enabled forward GPIOs
  function automatic logic [3:0] gpio_mask(input logic [1:0] count);
    case (count)
      2'h0: gpio_mask = 4'h0;
      2'h1: gpio_mask = 4'h1;
      2'h2: gpio_mask = 4'h3;
      default: gpio_mask = 4'hf;
    endcase
  endfunction : gpio_mask

  // One byte of MSB-first CRC-8
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc8_step = c;
  endfunction : crc8_step
endpackage : ccc_pkg

// File: ahb_reg_port.sv
`timescale 1ns/1ns
module ahb_reg_port
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register file side
  input wire logic [7:0] readData,
  output logic regWrite,
  output logic [7:0] regIndex,
  output logic [7:0] regWdata
);
  typedef struct packed {
    logic pending;
    logic isWrite;
    logic hit;
    logic [7:0] index;
    logic readyOut;
    logic [31:0] rdata;
  } port_state_type;

  port_state_type state, next_state;

  // One wait state: writes land and reads sample after earlier writes
  always_comb begin
    next_state = state;
    if (state.pending) begin
      next_state.pending = 1'b0;
      next_state.readyOut = 1'b1;
      next_state.rdata = (state.hit && !state.isWrite) ? {24'h0, readData} : 32'h0;
    end else if (hsel && htrans == HTRANS_NONSEQ && hready) begin
      next_state.pending = 1'b1;
      next_state.readyOut = 1'b0;
      next_state.isWrite = hwrite;
      next_state.index = haddr[9:2];
      next_state.hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= '{readyOut: 1'b1, index: 8'h0, rdata: 32'h0, default: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign hrdata = state.rdata;
  assign hreadyout = state.readyOut;
  assign hresp = HRESP_OKAY;
  assign regIndex = state.index;
  assign regWdata = hwdata[7:0];
  assign regWrite = state.pending && state.isWrite && state.hit;
endmodule : ahb_reg_port

// File: control_sequence_crc.sv
`timescale 1ns/1ns
module control_sequence_crc
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic crcOn,
  // Sequence bytes in
  input wire logic seqStart,
  input wire logic seqValid,
  input wire logic [7:0] seqByte,
  output logic seqReady,
  // Forward channel bytes out
  output logic fwdValid,
  output logic [7:0] fwdByte
);
  typedef struct packed {
    logic [3:0] count;
    logic [7:0] crc;
    logic slot;
    logic ready;
    logic valid;
    logic [7:0] dataOut;
  } crc_state_type;

  crc_state_type state, next_state;

  // CRC slot after the eighth byte stalls the source one cycle
  always_comb begin
    logic [7:0] base;
    logic [3:0] cnt;
    base = state.crc;
    cnt = state.count;
    next_state = state;
    next_state.valid = 1'b0;
    if (state.slot) begin
      next_state.valid = 1'b1;
      next_state.dataOut = state.crc;
      next_state.slot = 1'b0;
    end else if (seqValid) begin
      base = seqStart ? CRC_INIT : state.crc;
      cnt = seqStart ? 4'h0 : state.count;
      next_state.valid = 1'b1;
      next_state.dataOut = seqByte;
      if (cnt < CRC_DATA_BYTES) begin
        next_state.crc = crc8_step(base, seqByte);
        next_state.count = cnt + 4'h1;
      end
      next_state.slot = crcOn && (cnt == CRC_DATA_BYTES - 4'h1);
    end
    next_state.ready = !next_state.slot;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= '{ready: 1'b1, count: 4'h0, crc: 8'h0, dataOut: 8'h0, default: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign seqReady = state.ready;
  assign fwdValid = state.valid;
  assign fwdByte = state.dataOut;

  // Eighth byte with CRC on is followed by the CRC byte
  property p_crc_ninth;
    @(posedge clk_sys) disable iff (!nrst)
      (crcOn && seqValid && seqReady && !seqStart && state.count == 4'h7)
      |=> (fwdValid && !seqReady) ##1 (fwdValid && fwdByte == $past(state.crc) && seqReady);
  endproperty
  a_crc_ninth: assert property (p_crc_ninth) else $error("crc byte missing");
endmodule : control_sequence_crc

// File: control_channel_config_regs.sv
`timescale 1ns/1ns
module control_channel_config_regs
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Local I2C engine
  input wire logic i2cStart,
  input wire logic i2cDecodeHit,
  input wire logic i2cWriteDone,
  input wire logic fwdLocked,
  input wire logic remoteAck,
  output logic forwardTransaction,
  output logic localAck,
  // Back channel receive
  input wire logic backValid,
  input wire logic [7:0] backData,
  input wire logic backParity,
  input wire logic linkDetected,
  input wire logic capValid,
  input wire logic capSelftest,
  input wire logic capMultiPort,
  input wire logic [3:0] capPort,
  input wire logic idValid,
  input wire logic [6:0] idValue,
  output logic parityError,
  // Forward control sequence
  input wire logic seqStart,
  input wire logic seqValid,
  input wire logic [7:0] seqByte,
  output logic seqReady,
  output logic fwdValid,
  output logic [7:0] fwdByte,
  // Configuration levels
  output logic parityCheckOn,
  output logic [3:0] forwardGpioEnable,
  output logic linkSelftestRequest,
  output logic partnerMultiPort,
  output logic [3:0] partnerPort
);
  typedef struct packed {
    logic [7:0] chanCfg;
    logic [7:0] dataPath;
    logic [7:0] rsvd34;
    logic [7:0] capOne;
    logic [7:0] rsvd36;
    logic [7:0] partnerId;
    logic [7:0] rsvd38;
    logic forwardTransaction;
    logic localAck;
    logic parityError;
    logic [3:0] gpioEnable;
  } regs_state_type;

  regs_state_type state, next_state;

  logic regWrite;
  logic [7:0] regIndex;
  logic [7:0] regWdata;
  logic [7:0] readData;
  logic capWrite;
  logic idWrite;
  logic capFrozen;
  logic idFrozen;

  // Bus front end
  ahb_reg_port ahb_reg_port_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .readData(readData),
    .regWrite(regWrite),
    .regIndex(regIndex),
    .regWdata(regWdata)
  );

  // Forward control sequence with optional CRC byte
  control_sequence_crc control_sequence_crc_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .crcOn(state.dataPath[DP_CRC_ON]),
    .seqStart(seqStart),
    .seqValid(seqValid),
    .seqByte(seqByte),
    .seqReady(seqReady),
    .fwdValid(fwdValid),
    .fwdByte(fwdByte)
  );

  // Freeze seen this cycle, including a write landing now
  assign capWrite = regWrite && (regIndex == IDX_CAP_ONE);
  assign idWrite = regWrite && (regIndex == IDX_PARTNER_ID);
  assign capFrozen = capWrite ? regWdata[CAP_FREEZE] : state.capOne[CAP_FREEZE];
  assign idFrozen = idWrite ? regWdata[ID_FREEZE] : state.partnerId[ID_FREEZE];

  // Register read mux; unmapped indices read zero
  always_comb begin
    if (regIndex == IDX_CHAN_CFG) begin
      readData = state.chanCfg;
    end else if (regIndex == IDX_DATAPATH) begin
      readData = state.dataPath;
    end else if (regIndex == IDX_RSVD_34) begin
      readData = state.rsvd34;
    end else if (regIndex == IDX_CAP_ONE) begin
      readData = state.capOne;
    end else if (regIndex == IDX_RSVD_36) begin
      readData = state.rsvd36;
    end else if (regIndex == IDX_PARTNER_ID) begin
      readData = state.partnerId;
    end else if (regIndex == IDX_RSVD_38) begin
      readData = state.rsvd38;
    end else begin
      readData = 8'h0;
    end
  end

  // Register writes, back-channel loads and datapath decisions
  always_comb begin
    next_state = state;
    // Software writes; reserved bytes keep what is written
    if (regWrite) begin
      if (regIndex == IDX_CHAN_CFG) begin
        next_state.chanCfg = regWdata;
      end else if (regIndex == IDX_DATAPATH) begin
        next_state.dataPath = regWdata;
      end else if (regIndex == IDX_RSVD_34) begin
        next_state.rsvd34 = regWdata;
      end else if (regIndex == IDX_CAP_ONE) begin
        next_state.capOne = regWdata;
      end else if (regIndex == IDX_RSVD_36) begin
        next_state.rsvd36 = regWdata;
      end else if (regIndex == IDX_PARTNER_ID) begin
        next_state.partnerId = regWdata;
      end else if (regIndex == IDX_RSVD_38) begin
        next_state.rsvd38 = regWdata;
      end
    end
    // Channel load beats a same-cycle write unless frozen
    if (capValid && linkDetected && !capFrozen) begin
      next_state.capOne[CAP_SELFTEST] = capSelftest;
      next_state.capOne[CAP_MULTI_PORT] = capMultiPort;
      next_state.capOne[CAP_PORT_LSB +: 4] = capPort;
    end
    if (idValid && !idFrozen) begin
      next_state.partnerId[ID_LSB +: 7] = idValue;
    end
    // Pass-all wins over the decode result
    next_state.forwardTransaction = i2cStart && (state.chanCfg[CFG_PASS_ALL]
      || (state.chanCfg[CFG_PASS_DECODE] && i2cDecodeHit));
    // Ack-all ignores lock and remote answer
    next_state.localAck = i2cWriteDone && (state.chanCfg[CFG_ACK_ALL]
      || (fwdLocked && remoteAck));
    // Even parity expected on back-channel bytes
    next_state.parityError = backValid && state.chanCfg[CFG_PARITY_ON]
      && ((^backData) != backParity);
    next_state.gpioEnable = gpio_mask(next_state.dataPath[DP_GPIO_LSB +: 2]);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= '{chanCfg: RST_CHAN_CFG, dataPath: RST_DATAPATH, rsvd34: RST_ZERO,
        capOne: RST_ZERO, rsvd36: RST_ZERO, partnerId: {RST_PARTNER_ID, 1'b0},
        rsvd38: RST_ZERO, gpioEnable: 4'h0, default: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign forwardTransaction = state.forwardTransaction;
  assign localAck = state.localAck;
  assign parityError = state.parityError;
  assign parityCheckOn = state.chanCfg[CFG_PARITY_ON];
  assign forwardGpioEnable = state.gpioEnable;
  assign linkSelftestRequest = state.capOne[CAP_SELFTEST];
  assign partnerMultiPort = state.capOne[CAP_MULTI_PORT];
  assign partnerPort = state.capOne[CAP_PORT_LSB +: 4];

  // Pass-all forwards any start
  property p_pass_all;
    @(posedge clk_sys) disable iff (!nrst)
      (i2cStart && state.chanCfg[CFG_PASS_ALL]) |=> forwardTransaction;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("pass-all not forwarded");

  // Decode-only forwarding follows the hit
  property p_pass_decode;
    @(posedge clk_sys) disable iff (!nrst)
      (i2cStart && !state.chanCfg[CFG_PASS_ALL] && state.chanCfg[CFG_PASS_DECODE])
      |=> (forwardTransaction == $past(i2cDecodeHit));
  endproperty
  a_pass_decode: assert property (p_pass_decode) else $error("decode forward wrong");

  // Both bits off: nothing forwarded
  property p_pass_off;
    @(posedge clk_sys) disable iff (!nrst)
      (!state.chanCfg[CFG_PASS_ALL] && !state.chanCfg[CFG_PASS_DECODE])
      |=> !forwardTransaction;
  endproperty
  a_pass_off: assert property (p_pass_off) else $error("forward while disabled");

  // Pass-all overrides a decode miss
  property p_precedence;
    @(posedge clk_sys) disable iff (!nrst)
      (i2cStart && !i2cDecodeHit && state.chanCfg[CFG_PASS_ALL]
      && state.chanCfg[CFG_PASS_DECODE]) |=> forwardTransaction;
  endproperty
  a_precedence: assert property (p_precedence) else $error("precedence lost");

  // Ack-all acks even when unlocked
  property p_ack_all;
    @(posedge clk_sys) disable iff (!nrst)
      (i2cWriteDone && state.chanCfg[CFG_ACK_ALL]) |=> localAck;
  endproperty
  a_ack_all: assert property (p_ack_all) else $error("ack-all missed");

  // Parity fault flagged only while checking
  property p_parity;
    @(posedge clk_sys) disable iff (!nrst)
      backValid |=> (parityError == ($past(parityCheckOn)
      && ((^$past(backData)) != $past(backParity))));
  endproperty
  a_parity: assert property (p_parity) else $error("parity check wrong");

  // GPIO enables follow a write of the count field
  property p_gpio;
    @(posedge clk_sys) disable iff (!nrst)
      (regWrite && regIndex == IDX_DATAPATH)
      |=> (forwardGpioEnable == gpio_mask($past(regWdata[1:0])));
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio enable mismatch");

  // Frozen capabilities ignore channel updates
  property p_cap_freeze;
    @(posedge clk_sys) disable iff (!nrst)
      (capValid && state.capOne[CAP_FREEZE] && !regWrite)
      |=> $stable(state.capOne);
  endproperty
  a_cap_freeze: assert property (p_cap_freeze) else $error("frozen caps changed");

  // Unfrozen capabilities load from the channel
  property p_cap_load;
    @(posedge clk_sys) disable iff (!nrst)
      (capValid && linkDetected && !capFrozen)
      |=> (linkSelftestRequest == $past(capSelftest)
      && partnerMultiPort == $past(capMultiPort) && partnerPort == $past(capPort));
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("caps not loaded");

  // No load before the link is detected
  property p_cap_nolink;
    @(posedge clk_sys) disable iff (!nrst)
      (!linkDetected && !regWrite) |=> $stable(state.capOne);
  endproperty
  a_cap_nolink: assert property (p_cap_nolink) else $error("caps loaded unlinked");

  // Frozen identifier keeps its value
  property p_id_freeze;
    @(posedge clk_sys) disable iff (!nrst)
      (idValid && state.partnerId[ID_FREEZE] && !regWrite)
      |=> $stable(state.partnerId);
  endproperty
  a_id_freeze: assert property (p_id_freeze) else $error("frozen id changed");

  // Software write of the identifier sticks
  property p_id_write;
    @(posedge clk_sys) disable iff (!nrst)
      (idWrite && !idValid) |=> (state.partnerId == $past(regWdata));
  endproperty
  a_id_write: assert property (p_id_write) else $error("id write lost");
endmodule : control_channel_config_regs

// File: remote_partner_model.sv
`timescale 1ns/1ns
module remote_partner_model (
  // Clock
  input wire logic clk_sys,
  // Back channel toward the serializer
  output logic linkDetected,
  output logic backValid,
  output logic [7:0] backData,
  output logic backParity,
  output logic capValid,
  output logic capSelftest,
  output logic capMultiPort,
  output logic [3:0] capPort,
  output logic idValid,
  output logic [6:0] idValue
);
  // Quiet link; payload lines hold junk until a pulse qualifies them
  initial begin
    linkDetected = 1'b0;
    backValid = 1'b0;
    backData = 8'h5a;
    backParity = 1'b1;
    capValid = 1'b0;
    {capSelftest, capMultiPort, capPort} = 6'h2d;
    idValid = 1'b0;
    idValue = 7'h4b;
  end

  // Link comes and goes on a clock edge
  task automatic set_link(input logic v);
    @(posedge clk_sys);
    linkDetected <= v;
  endtask : set_link

  // One back byte; flip set breaks even parity on purpose
  task automatic send_back(input logic [7:0] d, input logic flip);
    @(posedge clk_sys);
    backValid <= 1'b1;
    backData <= d;
    backParity <= ^d ^ flip;
    @(posedge clk_sys);
    backValid <= 1'b0;
    backData <= ~d;
    backParity <= ~(^d ^ flip);
  endtask : send_back

  // Capability word for one cycle, inverted afterwards so stale values never match
  task automatic send_caps(input logic st, input logic mp, input logic [3:0] port);
    @(posedge clk_sys);
    capValid <= 1'b1;
    {capSelftest, capMultiPort, capPort} <= {st, mp, port};
    @(posedge clk_sys);
    capValid <= 1'b0;
    {capSelftest, capMultiPort, capPort} <= ~{st, mp, port};
  endtask : send_caps

  // Partner identifier for one cycle
  task automatic send_id(input logic [6:0] v);
    @(posedge clk_sys);
    idValid <= 1'b1;
    idValue <= v;
    @(posedge clk_sys);
    idValid <= 1'b0;
    idValue <= ~v;
  endtask : send_id
endmodule : remote_partner_model

// File: control_channel_config_regs_test.sv
`timescale 1ns/1ns
module control_channel_config_regs_test;
  import ccc_pkg::*;
  // Bench drive
  logic clk_sys = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic i2cStart = 1'b0, i2cDecodeHit = 1'b0, i2cWriteDone = 1'b0;
  logic fwdLocked = 1'b0, remoteAck = 1'b0, seqStart = 1'b0, seqValid = 1'b0;
  logic [7:0] seqByte = 8'h00;
  // Design and partner outputs
  logic [31:0] hrdata;
  logic hreadyout, hresp, forwardTransaction, localAck, parityError, seqReady, fwdValid;
  logic parityCheckOn, linkSelftestRequest, partnerMultiPort;
  logic [7:0] fwdByte;
  logic [3:0] forwardGpioEnable, partnerPort, capPort;
  logic linkDetected, backValid, backParity, capValid, capSelftest, capMultiPort, idValid;
  logic [7:0] backData;
  logic [6:0] idValue;
  // Reference model state
  int error_cnt = 0, checks_done = 0, cycles = 0, seed = 922;
  logic [7:0] mdl [50:56];
  logic [3:0] gmask [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
  logic [31:0] rd;
  logic [8:0] outQ[$], expQ[$];
  logic [7:0] crc, b;

  control_channel_config_regs control_channel_config_regs_inst (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .i2cStart(i2cStart), .i2cDecodeHit(i2cDecodeHit),
    .i2cWriteDone(i2cWriteDone), .fwdLocked(fwdLocked), .remoteAck(remoteAck),
    .forwardTransaction(forwardTransaction), .localAck(localAck), .backValid(backValid),
    .backData(backData), .backParity(backParity), .linkDetected(linkDetected),
    .capValid(capValid), .capSelftest(capSelftest), .capMultiPort(capMultiPort),
    .capPort(capPort), .idValid(idValid), .idValue(idValue), .parityError(parityError),
    .seqStart(seqStart), .seqValid(seqValid), .seqByte(seqByte), .seqReady(seqReady),
    .fwdValid(fwdValid), .fwdByte(fwdByte), .parityCheckOn(parityCheckOn),
    .forwardGpioEnable(forwardGpioEnable), .linkSelftestRequest(linkSelftestRequest),
    .partnerMultiPort(partnerMultiPort), .partnerPort(partnerPort));

  remote_partner_model partner_inst (
    .clk_sys(clk_sys), .linkDetected(linkDetected), .backValid(backValid),
    .backData(backData), .backParity(backParity), .capValid(capValid),
    .capSelftest(capSelftest), .capMultiPort(capMultiPort), .capPort(capPort),
    .idValid(idValid), .idValue(idValue));

  // Clock and hang guard; under a thousand cycles are expected
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // Forward byte monitor, keeps ready beside each byte
  always @(posedge clk_sys) begin
    if (fwdValid === 1'b1) outQ.push_back({seqReady, fwdByte});
  end

  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Single word transfer; no wait count assumed, bounded only against a hang
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 20);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 20);
    rd = hrdata;
    chk(hresp, HRESP_OKAY);
    if (n >= 20) chk(1'b0, 1'b1);
  endtask : ahb

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    ahb(1'b1, idx, v);
    if (idx >= IDX_CHAN_CFG && idx <= IDX_RSVD_38) mdl[idx] = v;
  endtask : wr

  // Read compared with the model; unmapped words read zero
  task automatic rdchk(input logic [7:0] idx);
    ahb(1'b0, idx, 8'($random(seed)));
    chk(rd, (idx >= IDX_CHAN_CFG && idx <= IDX_RSVD_38) ? {24'h0, mdl[idx]} : 32'h0);
  endtask : rdchk

  task automatic caps(input logic [5:0] c);
    partner_inst.send_caps(c[5], c[4], c[3:0]);
    if (linkDetected === 1'b1 && !mdl[IDX_CAP_ONE][CAP_FREEZE]) mdl[IDX_CAP_ONE][5:0] = c;
    @(negedge clk_sys);
    chk({linkSelftestRequest, partnerMultiPort, partnerPort}, mdl[IDX_CAP_ONE][5:0]);
    rdchk(IDX_CAP_ONE);
  endtask : caps

  task automatic ident(input logic [6:0] v);
    partner_inst.send_id(v);
    if (!mdl[IDX_PARTNER_ID][ID_FREEZE]) mdl[IDX_PARTNER_ID][7:1] = v;
    rdchk(IDX_PARTNER_ID);
  endtask : ident

  // Bitwise reference, written apart from the design's own helper
  function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] d);
    int x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = ((x << 1) ^ ((x & 128) ? int'(CRC_POLY) : 0)) & 255;
    return 8'(x);
  endfunction : crc_next

  initial begin
    mdl = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h00, {RST_PARTNER_ID, 1'b0}, 8'h00};
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values, then an unmapped word that must ignore writes
    for (int a = 8'h32; a <= 8'h38; a++) rdchk(8'(a));
    chk(parityCheckOn, 1'b1);
    chk(forwardGpioEnable, 4'h0);
    wr(8'h40, 8'hff);
    rdchk(8'h40);
    for (int a = 8'h34; a <= 8'h38; a += 2) begin
      wr(8'(a), 8'($random(seed)));
      rdchk(8'(a));
    end
    // Every GPIO count code
    for (int g = 0; g < 4; g++) begin
      wr(IDX_DATAPATH, {5'($random(seed)), 1'b1, 2'(g)});
      @(negedge clk_sys);
      chk(forwardGpioEnable, gmask[g]);
      rdchk(IDX_DATAPATH);
    end
    // All pass and ack settings against all decode, lock and remote-ack conditions, start and write-done always set
    for (int k = 0; k < 64; k++) begin
      wr(IDX_CHAN_CFG, {k[5:3], 5'h09});
      @(posedge clk_sys);
      i2cStart <= 1'b1;
      i2cWriteDone <= 1'b1;
      i2cDecodeHit <= k[2];
      fwdLocked <= k[1];
      remoteAck <= k[0];
      @(posedge clk_sys);
      i2cStart <= 1'b0;
      i2cWriteDone <= 1'b0;
      @(negedge clk_sys);
      chk(forwardTransaction, k[5] | (k[4] & k[2]));
      chk(localAck, k[3] | (k[1] & k[0]));
    end
    // Parity checker on and off, good and bad bytes
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CHAN_CFG, {4'h0, k[1], 3'h1});
      @(negedge clk_sys);
      chk(parityCheckOn, k[1]);
      partner_inst.send_back(8'($random(seed)), k[0]);
      @(negedge clk_sys);
      chk(parityError, k[1] & k[0]);
    end
    // Capabilities: no link, link, software override with freeze, thaw
    caps(6'h35);
    partner_inst.set_link(1'b1);
    caps(6'($random(seed)));
    wr(IDX_CAP_ONE, 8'haa);
    caps(6'h15);
    wr(IDX_CAP_ONE, 8'h00);
    caps(6'h3f);
    // Identifier load, software write, freeze
    ident(7'($random(seed)));
    wr(IDX_PARTNER_ID, 8'h22);
    rdchk(IDX_PARTNER_ID);
    wr(IDX_PARTNER_ID, 8'h67);
    ident(7'h55);
    // Control sequence with CRC slot, then without
    for (int on = 1; on >= 0; on--) begin
      wr(IDX_DATAPATH, {5'h00, 1'(on), 2'h0});
      outQ = {};
      expQ = {};
      crc = CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        b = 8'($random(seed));
        // Ready drops beside the eighth echo while the CRC slot is pending
        expQ.push_back({(on == 0 || i != 7), b});
        crc = crc_next(crc, b);
        @(posedge clk_sys);
        seqStart <= (i == 0);
        seqValid <= 1'b1;
        seqByte <= b;
      end
      @(posedge clk_sys);
      seqValid <= 1'b0;
      seqStart <= 1'b0;
      seqByte <= ~b;
      if (on == 1) expQ.push_back({1'b1, crc});
      repeat (4) @(posedge clk_sys);
      chk(outQ.size(), expQ.size());
      foreach (expQ[i]) chk(outQ[i], expQ[i]);
    end
    finish_test();
  end
endmodule : control_channel_config_regs_test
